// file: inc/iit_pkg.sv
package iit_pkg;
    // Register byte addresses on the controller's Avalon-MM slave
    localparam logic [3:0] ADDR_CTRL = 4'h0;
    localparam logic [3:0] ADDR_START = 4'h4;
    localparam logic [3:0] ADDR_END = 4'h8;
    localparam logic [3:0] ADDR_STATUS = 4'hc;
    // Control word layout
    localparam int CTL_RUN = 0;
    localparam int CTL_DIR = 1;
    localparam int CTL_RELOAD = 2;
    localparam int CTL_CONT = 3;
    localparam int CTL_OE = 4;
    localparam int CTL_PRE_LSB = 8;
    localparam int PRE_W = 4;
    localparam int CNT_W = 16;
    localparam int CTL_W = 12;
    localparam logic [CTL_W-1:0] CTL_RESET = 12'h000;
    localparam logic [CNT_W-1:0] CNT_RESET = 16'h0000;
    // Status word layout
    localparam int STS_MATCH = 0;
    localparam int STS_TRIG = 1;
    localparam int STS_RUN = 2;
    localparam int STS_CNT_LSB = 16;
    // Shortest count period is 2^PRE_MIN_EXP clocks
    localparam int PRE_MIN_EXP = 2;
    localparam int PRE_DIV_W = PRE_MIN_EXP + (1 << PRE_W);
    // Trigger pulse width in CPU clocks
    localparam int TRIG_CYCLES = 12;
    localparam logic [3:0] TRIG_CNT_INIT = 4'(TRIG_CYCLES);
    localparam int PERIPH_BIT = 10;
endpackage

// file: inc/iit_if.sv
`timescale 1ns/1ps
`default_nettype none
interface iit_if;
    logic [iit_pkg::CTL_W-1:0] ctrl;
    logic [iit_pkg::CNT_W-1:0] start_val;
    logic [iit_pkg::CNT_W-1:0] end_val;
    logic [iit_pkg::CNT_W-1:0] count_val;
    logic match;
    logic trig_o;
    logic trig_oe;
    logic ext_periph_enable;
    logic [15:0] periph_enable_reg;
    modport device (
        input ctrl, start_val, end_val, ext_periph_enable, periph_enable_reg,
        output count_val, match, trig_o, trig_oe
    );
    modport host (
        output ctrl, start_val, end_val, ext_periph_enable, periph_enable_reg,
        input count_val, match, trig_o, trig_oe
    );
endinterface
`default_nettype wire

// file: src/iit_timer.sv
// Implementation choices: the address map and the Avalon-MM slave port.
`timescale 1ns/1ps
`default_nettype none
module iit_timer (
    input wire logic clk_in,
    input wire logic rstn_in,
    iit_if.device link,
    output logic [iit_pkg::CNT_W-1:0] count_value_reg_out,
    output logic injection_trigger_out
);
    localparam int DW = iit_pkg::PRE_DIV_W;
    localparam int CW = iit_pkg::CNT_W;
    localparam int PW = iit_pkg::PRE_W;
    localparam logic [CW-1:0] CNT_ONE = CW'(1);
    localparam logic [3:0] PULSE_ONE = 4'h1;
    localparam logic [3:0] PULSE_IDLE = 4'h0;

    // Run phases; a stop-mode match parks in HOLD so the trigger fires once
    typedef enum logic [3:0] {
        ST_IDLE = 4'h1,
        ST_LOAD = 4'h2,
        ST_COUNT = 4'h4,
        ST_HOLD = 4'h8
    } iit_state_t;

    iit_state_t state_r;
    iit_state_t state_nxt;
    logic [DW-1:0] div_r;
    logic [DW-1:0] div_nxt;
    logic [DW-1:0] div_mask;
    logic [CW-1:0] cnt_r;
    logic [CW-1:0] cnt_nxt;
    logic [3:0] pulse_r;
    logic [3:0] pulse_nxt;
    logic trig_r;
    logic trig_nxt;
    logic match_r;
    logic oe_r;

    // Control word fields
    wire logic [iit_pkg::CTL_W-1:0] ctl = link.ctrl;
    wire logic run = ctl[iit_pkg::CTL_RUN];
    wire logic dir_up = ctl[iit_pkg::CTL_DIR];
    wire logic reload = ctl[iit_pkg::CTL_RELOAD];
    wire logic cont = ctl[iit_pkg::CTL_CONT];
    wire logic oe = ctl[iit_pkg::CTL_OE];
    wire logic [PW-1:0] pre = ctl[iit_pkg::CTL_PRE_LSB +: PW];

    // Both system enables gate the prescaler, hence every counter update
    wire logic periph_bit = link.periph_enable_reg[iit_pkg::PERIPH_BIT];
    wire logic enabled = link.ext_periph_enable && periph_bit;
    wire logic active = enabled && run;

    // Low prescaler bits all set gives one tick every 2^(pre+2) clocks
    genvar gi;
    generate
        for (gi = 0; gi < DW; gi++) begin : g_mask
            assign div_mask[gi] = (gi < (int'(pre) + iit_pkg::PRE_MIN_EXP));
        end
    endgenerate

    wire logic tick = active && ((div_r & div_mask) == div_mask);
    wire logic at_end = (cnt_r == link.end_val);
    wire logic [CW-1:0] cnt_up = cnt_r + CNT_ONE;
    wire logic [CW-1:0] cnt_down = cnt_r - CNT_ONE;
    wire logic [CW-1:0] cnt_step = dir_up ? cnt_up : cnt_down;
    // A start on the wrong side would meet the end value only after wrapping, so it parks
    wire logic start_above = (link.start_val > link.end_val);
    wire logic start_below = (link.start_val < link.end_val);
    wire logic wrong_start = dir_up ? start_above : start_below;
    wire logic in_count = (state_r == ST_COUNT);
    wire logic loaded = (state_r == ST_COUNT) || (state_r == ST_HOLD);
    wire logic end_tick = tick && in_count && at_end;
    wire logic do_trig = end_tick && oe;

    assign div_nxt = active ? div_r + DW'(1) : '0;

    always_comb begin
        state_nxt = state_r;
        unique case (state_r)
            ST_IDLE: begin
                if (run) begin
                    state_nxt = ST_LOAD;
                end
            end
            ST_LOAD: begin
                if (tick) begin
                    state_nxt = wrong_start ? ST_HOLD : ST_COUNT;
                end
            end
            ST_COUNT: begin
                if (end_tick && !cont) begin
                    state_nxt = ST_HOLD;
                end
            end
            ST_HOLD: begin
                state_nxt = ST_HOLD;
            end
            default: begin
                state_nxt = ST_IDLE;
            end
        endcase
        // Dropping run abandons the period; the next start reloads
        if (!run) begin
            state_nxt = ST_IDLE;
        end
    end

    always_comb begin
        cnt_nxt = cnt_r;
        unique case (state_r)
            ST_LOAD: begin
                cnt_nxt = link.start_val;
            end
            ST_COUNT: begin
                if (!at_end) begin
                    cnt_nxt = cnt_step;
                end else if (!cont) begin
                    cnt_nxt = cnt_r;
                end else if (reload) begin
                    cnt_nxt = link.start_val;
                end else begin
                    cnt_nxt = cnt_step;
                end
            end
            default: begin
                cnt_nxt = cnt_r;
            end
        endcase
    end

    // Width counted in CPU clocks, so it does not stretch with the prescaler
    always_comb begin
        pulse_nxt = pulse_r;
        trig_nxt = trig_r;
        if (do_trig) begin
            pulse_nxt = iit_pkg::TRIG_CNT_INIT - PULSE_ONE;
            trig_nxt = 1'b1;
        end else if (pulse_r != PULSE_IDLE) begin
            pulse_nxt = pulse_r - PULSE_ONE;
        end else begin
            trig_nxt = 1'b0;
        end
    end

    always_ff @(posedge clk_in or negedge rstn_in) begin
        if (!rstn_in) begin
            state_r <= ST_IDLE;
            div_r <= '0;
        end else begin
            state_r <= state_nxt;
            div_r <= div_nxt;
        end
    end

    always_ff @(posedge clk_in or negedge rstn_in) begin
        if (!rstn_in) begin
            cnt_r <= iit_pkg::CNT_RESET;
        end else if (tick) begin
            cnt_r <= cnt_nxt;
        end
    end

    always_ff @(posedge clk_in or negedge rstn_in) begin
        if (!rstn_in) begin
            pulse_r <= PULSE_IDLE;
            trig_r <= 1'b0;
        end else begin
            pulse_r <= pulse_nxt;
            trig_r <= trig_nxt;
        end
    end

    always_ff @(posedge clk_in or negedge rstn_in) begin
        if (!rstn_in) begin
            match_r <= 1'b0;
            oe_r <= 1'b0;
        end else begin
            match_r <= loaded && at_end;
            oe_r <= oe;
        end
    end

    assign link.count_val = cnt_r;
    assign link.match = match_r;
    assign link.trig_o = trig_r;
    assign link.trig_oe = oe_r;
    assign count_value_reg_out = cnt_r;
    assign injection_trigger_out = trig_r;
endmodule
`default_nettype wire

// file: src/iit_ctrl.sv
`timescale 1ns/1ps
`default_nettype none
// Software side: holds the timer's configuration and registers the system enables from its input pins
module iit_ctrl (
    input wire logic clk_in,
    input wire logic rstn_in,
    iit_if.host link,
    input wire logic [3:0] avs_address_in,
    input wire logic avs_read_in,
    input wire logic avs_write_in,
    input wire logic [31:0] avs_writedata_in,
    output logic [31:0] avs_readdata_out,
    output logic avs_waitrequest_out,
    input wire logic ext_periph_enable_in,
    input wire logic [15:0] periph_enable_reg_in
);
    logic [iit_pkg::CTL_W-1:0] ctl_r;
    logic [iit_pkg::CNT_W-1:0] start_r;
    logic [iit_pkg::CNT_W-1:0] end_r;
    logic [31:0] rdata_r;
    logic ack_r;
    logic en_r;
    logic [15:0] pen_r;

    wire logic req = (avs_read_in || avs_write_in) && !ack_r;
    // Writes land on the answering edge, where the master sees waitrequest low
    wire logic wr = avs_write_in && ack_r;
    wire logic [31:0] status = {link.count_val, 13'h0000, link.ctrl[iit_pkg::CTL_RUN],
        link.trig_o, link.match};
    wire logic [31:0] rmux =
        (avs_address_in == iit_pkg::ADDR_CTRL) ? {20'h00000, ctl_r} :
        (avs_address_in == iit_pkg::ADDR_START) ? {16'h0000, start_r} :
        (avs_address_in == iit_pkg::ADDR_END) ? {16'h0000, end_r} :
        (avs_address_in == iit_pkg::ADDR_STATUS) ? status : 32'h00000000;

    // One wait cycle per access; waitrequest drops one edge before the answering edge
    always_ff @(posedge clk_in or negedge rstn_in) begin
        if (!rstn_in) begin
            ctl_r <= iit_pkg::CTL_RESET;
            start_r <= iit_pkg::CNT_RESET;
            end_r <= iit_pkg::CNT_RESET;
            rdata_r <= 32'h00000000;
            ack_r <= 1'b0;
            en_r <= 1'b0;
            pen_r <= 16'h0000;
        end else begin
            en_r <= ext_periph_enable_in;
            pen_r <= periph_enable_reg_in;
            ack_r <= req;
            if (req) begin
                rdata_r <= rmux;
            end
            if (wr && avs_address_in == iit_pkg::ADDR_CTRL) begin
                ctl_r <= avs_writedata_in[iit_pkg::CTL_W-1:0];
            end
            if (wr && avs_address_in == iit_pkg::ADDR_START) begin
                start_r <= avs_writedata_in[iit_pkg::CNT_W-1:0];
            end
            if (wr && avs_address_in == iit_pkg::ADDR_END) begin
                end_r <= avs_writedata_in[iit_pkg::CNT_W-1:0];
            end
        end
    end

    assign avs_waitrequest_out = !ack_r;
    assign avs_readdata_out = rdata_r;
    assign link.ctrl = ctl_r;
    assign link.start_val = start_r;
    assign link.end_val = end_r;
    assign link.ext_periph_enable = en_r;
    assign link.periph_enable_reg = pen_r;
endmodule
`default_nettype wire

// file: bench/iit_sva.sv
`timescale 1ns/1ps
`default_nettype none
module iit_sva (
    input wire logic clk_in,
    input wire logic rstn_in,
    input wire logic [iit_pkg::CTL_W-1:0] ctrl,
    input wire logic [iit_pkg::CNT_W-1:0] start_val,
    input wire logic [iit_pkg::CNT_W-1:0] end_val,
    input wire logic [iit_pkg::CNT_W-1:0] count_val,
    input wire logic match,
    input wire logic trig_o,
    input wire logic trig_oe,
    input wire logic ext_periph_enable,
    input wire logic [15:0] periph_enable_reg
);
    default clocking @(posedge clk_in); endclocking
    default disable iff (!rstn_in);
    wire en = ext_periph_enable && periph_enable_reg[iit_pkg::PERIPH_BIT];
    hold_off_a: assert property (!ctrl[0] |=> $stable(count_val))
        else $error("count moved while stopped");
    step_one_a: assert property ($changed(count_val) |-> count_val == $past(start_val) ||
        count_val == ($past(ctrl[1]) ? $past(count_val) + 16'h1 : $past(count_val) - 16'h1))
        else $error("count jumped");
    trig_width_a: assert property ($rose(trig_o) |-> trig_o [*8] ##1 trig_o [*4] ##1 !trig_o)
        else $error("trigger width wrong");
    trig_cause_a: assert property ($rose(trig_o) |->
        $past(trig_oe) && $past(count_val) == $past(end_val))
        else $error("trigger without match");
    stop_hold_a: assert property (match && ctrl[0] && !ctrl[3] |=> $stable(count_val))
        else $error("stop mode kept counting");
    enables_gate_a: assert property (!en |=> $stable(count_val))
        else $error("count moved while disabled");
    min_period_a: assert property ($changed(count_val) |=> $stable(count_val) [*3])
        else $error("count period below four clocks");
    start_load_a: assert property ($rose(ctrl[0]) && en && ctrl[11:8] == 4'h0 |->
        ##[1:8] count_val == start_val)
        else $error("start value not loaded");
endmodule
`default_nettype wire

// file: bench/tb_adc_injection_interval_timer.sv
`timescale 1ns/1ps
`default_nettype none
module tb_adc_injection_interval_timer;
    logic clk_in = 0, rstn_in = 0, rd = 0, wr = 0, ext_en = 1, waitreq, trig;
    logic [3:0] addr = 0;
    logic [31:0] wdata = 0, rdata, q, rnd = 32'hb453;
    logic [15:0] pen = 16'h0400, cnt;
    int failures = 0, samples_checked = 0, rises, gap, width;
    iit_if link_bus();
    // Trigger pin floats whenever the output enable is off
    wire trig_pin = link_bus.trig_oe ? link_bus.trig_o : 1'bz;
    always #5 clk_in = ~clk_in;
    iit_ctrl iit_ctrl_inst (.clk_in(clk_in), .rstn_in(rstn_in), .link(link_bus),
        .avs_address_in(addr), .avs_read_in(rd), .avs_write_in(wr), .avs_writedata_in(wdata),
        .avs_readdata_out(rdata), .avs_waitrequest_out(waitreq),
        .ext_periph_enable_in(ext_en), .periph_enable_reg_in(pen));
    iit_timer iit_timer_inst (.clk_in(clk_in), .rstn_in(rstn_in), .link(link_bus),
        .count_value_reg_out(cnt), .injection_trigger_out(trig));
    iit_sva iit_sva_inst (.clk_in(clk_in), .rstn_in(rstn_in), .ctrl(link_bus.ctrl),
        .start_val(link_bus.start_val), .end_val(link_bus.end_val),
        .count_val(link_bus.count_val), .match(link_bus.match), .trig_o(link_bus.trig_o),
        .trig_oe(link_bus.trig_oe), .ext_periph_enable(link_bus.ext_periph_enable),
        .periph_enable_reg(link_bus.periph_enable_reg));
    function automatic logic [31:0] lfsr(input logic [31:0] v);
        return {v[30:0], v[31] ^ v[21] ^ v[1] ^ v[0]};
    endfunction
    function automatic logic [31:0] gap_of(input int p, input int len);
        return 32'(len << (p + 2));
    endfunction
    task automatic check(input string what, input logic [31:0] got, input logic [31:0] exp);
        samples_checked++;
        if (got !== exp) begin
            failures++;
            $display("ERROR %s expected %h seen %h", what, exp, got);
        end
    endtask
    task automatic test_done;
        $display("checked %0d failures %0d", samples_checked, failures);
        if (failures == 0 && samples_checked > 0) $display("Regression OK");
        else $display("Regression broken");
        $finish;
    endtask
    task automatic bus(input logic [3:0] a, input logic w, input logic [31:0] d);
        addr <= a;
        wr <= w;
        rd <= !w;
        wdata <= d;
        do @(posedge clk_in); while (waitreq !== 1'b0);
        q = rdata;
        rd <= 1'b0;
        wr <= 1'b0;
        @(posedge clk_in);
    endtask
    // Configuration only changes while stopped; run goes up on a second write
    task automatic run_cfg(input logic [11:0] c, input logic [15:0] s, input logic [15:0] e);
        bus(iit_pkg::ADDR_CTRL, 1'b1, 32'(c));
        bus(iit_pkg::ADDR_START, 1'b1, 32'(s));
        bus(iit_pkg::ADDR_END, 1'b1, 32'(e));
        bus(iit_pkg::ADDR_CTRL, 1'b1, 32'(c | 12'h001));
    endtask
    task automatic watch(input int n);
        int t0 = 0, h = 0;
        logic prev = 1'b0;
        rises = 0;
        gap = 0;
        width = 0;
        for (int i = 0; i < n; i++) begin
            @(posedge clk_in);
            if (trig === 1'b1 && !prev) begin
                rises++;
                if (rises == 2) gap = i - t0;
                t0 = i;
            end
            h = (trig === 1'b1) ? h + 1 : 0;
            if (h > width) width = h;
            prev = (trig === 1'b1);
        end
    endtask
    initial begin
        repeat (8) @(posedge clk_in);
        rstn_in <= 1'b1;
        @(posedge clk_in);
        bus(iit_pkg::ADDR_CTRL, 1'b0, 0);
        check("ctrl reset", q, 32'(iit_pkg::CTL_RESET));
        bus(4'h2, 1'b1, 32'hffffffff);
        bus(4'h2, 1'b0, 0);
        check("unmapped", q, 32'h0);
        rnd = lfsr(rnd);
        pen <= rnd[15:0] | 16'h0400;
        run_cfg(12'h010, {14'h0, rnd[17:16]} + 16'h2, 16'h0);
        watch(200);
        check("stop rises", rises, 1);
        check("pulse width", width, 12);
        check("stop count", cnt, 0);
        bus(iit_pkg::ADDR_STATUS, 1'b0, 0);
        check("status", q, 32'h00000005);
        for (int p = 0; p < 3; p++) begin
            rnd = lfsr(rnd);
            run_cfg(12'h01e | 12'(p << 8), rnd[15:0] & 16'h7fff, (rnd[15:0] & 16'h7fff) + 16'h3);
            watch(600);
            check("reload gap", gap, gap_of(p, 4));
            check("reload width", width, 12);
        end
        run_cfg(12'h01a, 16'h10, 16'h11);
        watch(100);
        check("cont rises", rises, 1);
        check("cont past end", cnt > 16'h11, 1);
        run_cfg(12'h000, 16'h2, 16'h0);
        watch(100);
        check("oe off rises", rises, 0);
        check("oe off pin", trig_pin === 1'bz, 1);
        run_cfg(12'h010, 16'h1, 16'h5);
        watch(100);
        check("wrong side", cnt, 1);
        check("wrong side rises", rises, 0);
        for (int k = 0; k < 2; k++) begin
            ext_en <= k[0];
            pen <= k[0] ? 16'hfbff : 16'h0400;
            run_cfg(12'h010, 16'h3, 16'h0);
            watch(100);
            check("disabled", cnt, 1);
        end
        test_done();
    end
    initial begin
        #200us;
        failures++;
        test_done();
    end
endmodule
`default_nettype wire
